// file: src/io_bod_consts.svh
// Offsets, field positions, reset values and timing counts of the I/O brown-out block.
// Included by the package and the design; holds definitions only.
`ifndef IO_BOD_CONSTS_SVH
`define IO_BOD_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BOD_OFF_FLAGS 8'h08
`define BOD_OFF_STATUS 8'h0c
`define BOD_OFF_CONTROL 8'h10

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define BOD_BATT_LVL_HI 29
`define BOD_BATT_LVL_LO 24
`define BOD_MAIN_LVL_HI 21
`define BOD_MAIN_LVL_LO 16
`define BOD_PSEL_HI 15
`define BOD_PSEL_LO 12
`define BOD_MON_SEL_BIT 10
`define BOD_ACT_SAMP_BIT 8
`define BOD_RUNBK_BIT 7
`define BOD_RUNSB_BIT 6
`define BOD_SBCFG_BIT 5
`define BOD_ACTION_HI 4
`define BOD_ACTION_LO 3
`define BOD_HYSTERESIS_BIT 2
`define BOD_ENABLE_BIT 1

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define BOD_ST_BATT 11
`define BOD_ST_CORE 10
`define BOD_ST_APWS 9
`define BOD_ST_VREG 8
`define BOD_ST_SYNC 2
`define BOD_ST_DET 1
`define BOD_ST_RDY 0
`define BOD_FLAG_MASK 32'h0000_0707

// ----------------------------------------
// Action codes, reset values, timing
// ----------------------------------------
`define BOD_ACT_NONE 2'h0
`define BOD_ACT_RESET 2'h1
`define BOD_ACT_INT 2'h2
`define BOD_ACT_BKUP 2'h3
`define BOD_PSEL_RESET 4'h0
`define BOD_LVL_RESET 6'h00
`define BOD_SYNC_CYCLES 4'h3

`endif

// file: src/io_bod_pkg.sv
// Types shared by the I/O brown-out control and status block.
// Assumes the constants header is on the include path.
`include "io_bod_consts.svh"

package io_bod_pkg;

  // Power mode reported by the power manager
  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_STANDBY,
    MODE_BACKUP
  } sleep_mode_t;

  // Supply state from the switches and regulators
  typedef struct packed {
    logic battery_powered;
    logic core_voltage_ok;
    logic auto_switch_ready;
    logic regulator_ready;
  } supply_in_t;

  // Start-up values from the non-volatile user row
  typedef struct packed {
    logic [1:0] action;
    logic enable;
    logic hysteresis;
    logic [5:0] level;
  } user_row_t;

  // Signals driven to the analog comparator
  typedef struct packed {
    logic enable;
    logic sample;
    logic monitor_battery;
    logic hysteresis;
    logic [5:0] level;
  } comp_ctrl_t;

  // Write synchronisation of the enable bit
  typedef enum logic [1:0] {
    SYNC_IDLE,
    SYNC_BUSY
  } sync_state_t;

endpackage

// file: src/io_brownout_ctrl_status.sv
// I/O brown-out detector control word, supply status and event flags.
// Assumes a register port synchronous to clk, a one-cycle 1 kHz tick from
// the low-power oscillator, and an analog comparator behind comp_ctrl.
//
// Behaviour
// - status bit 11 shows battery backup supply
// - status bit 10 shows core voltage reached
// - status bit 9 shows auto switch ready
// - status bit 8 shows selected regulator supplying
// - status bit 2 low while write syncs
// - status bit 1 shows supply below threshold
// - status bit 0 ready, reset from user row
// - control at 0x10, synced, protected, lockable
// - bits 29:24 battery threshold, reset zero
// - bits 21:16 main threshold, from user row
// - bits 15:12 prescaler, divide 2^(code+1)
// - prescaler counts 1 kHz oscillator ticks
// - bit 10 selects main or battery supply
// - bit 8 active continuous or sampling
// - bit 7 backup sleep off or sampling
// - threshold and mode bits apply directly
// - action and enable reset from user row
// - action field picks crossing response
// - standby run and standby sampling select
// - flags set on rise except bit 11, write one clears
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "io_bod_consts.svh"

module io_brownout_ctrl_status
#(
  parameter int SYNC_CYCLES = `BOD_SYNC_CYCLES
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic write_lock,
  input wire io_bod_pkg::user_row_t user_row,
  input wire io_bod_pkg::supply_in_t supply_in,
  input wire io_bod_pkg::sleep_mode_t sleep_mode,
  input wire logic osc_1khz_tick,
  input wire logic comp_below,
  output io_bod_pkg::comp_ctrl_t comp_ctrl,
  output logic bod_reset_req,
  output logic bod_int_req,
  output logic bod_backup_req
);
  import io_bod_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic init_done_r;
  logic [5:0] batt_lvl_r;
  logic [5:0] main_lvl_r;
  logic [3:0] psel_r;
  logic mon_batt_r;
  logic act_samp_r;
  logic runbk_r;
  logic runsb_r;
  logic sbcfg_r;
  logic [1:0] action_r;
  logic hysteresis_r;
  logic enable_r;
  logic enable_pend_r;
  sync_state_t sync_r;
  logic [3:0] sync_cnt_r;
  logic ready_r;
  logic det_r;
  logic det_prev_r;
  logic [11:0] status_r;
  logic [11:0] status_prev_r;
  logic [11:0] flags_r;
  logic [15:0] pre_cnt_r;
  logic sample_r;
  logic run_nxt;
  logic sampling_nxt;
  logic ctrl_wr;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] rdata_nxt;

  // Prescaler terminal count for divide by 2^(code+1)
  function automatic logic [15:0] pre_term(input logic [3:0] code);
    logic [16:0] full;
    full = 17'h00002 << code;
    return 16'(full - 17'h00001);
  endfunction

  // ----------------------------------------
  // Write decode and user-row capture
  // ----------------------------------------
  // Locked writes are dropped without an answer
  assign ctrl_wr = wr && addr == `BOD_OFF_CONTROL && !write_lock && init_done_r;

  // Reset values that come from the user row are loaded on the first edge after release
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      init_done_r <= 1'b0;
    else
      init_done_r <= 1'b1;
  end

  // ----------------------------------------
  // Control word fields
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      batt_lvl_r <= `BOD_LVL_RESET;
      main_lvl_r <= `BOD_LVL_RESET;
      psel_r <= `BOD_PSEL_RESET;
      mon_batt_r <= 1'b0;
      act_samp_r <= 1'b0;
      runbk_r <= 1'b0;
      runsb_r <= 1'b0;
      sbcfg_r <= 1'b0;
      action_r <= `BOD_ACT_NONE;
      hysteresis_r <= 1'b0;
    end
    else if (!init_done_r)
    begin
      main_lvl_r <= user_row.level;
      action_r <= user_row.action;
      hysteresis_r <= user_row.hysteresis;
    end
    else if (ctrl_wr && !enable_r)
    begin
      // Protected fields change only while the detector is off
      batt_lvl_r <= wdata[`BOD_BATT_LVL_HI:`BOD_BATT_LVL_LO];
      main_lvl_r <= wdata[`BOD_MAIN_LVL_HI:`BOD_MAIN_LVL_LO];
      psel_r <= wdata[`BOD_PSEL_HI:`BOD_PSEL_LO];
      mon_batt_r <= wdata[`BOD_MON_SEL_BIT];
      act_samp_r <= wdata[`BOD_ACT_SAMP_BIT];
      runbk_r <= wdata[`BOD_RUNBK_BIT];
      runsb_r <= wdata[`BOD_RUNSB_BIT];
      sbcfg_r <= wdata[`BOD_SBCFG_BIT];
      action_r <= wdata[`BOD_ACTION_HI:`BOD_ACTION_LO];
      hysteresis_r <= wdata[`BOD_HYSTERESIS_BIT];
    end
  end

  // ----------------------------------------
  // Enable bit with write synchronisation
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_r <= SYNC_IDLE;
      sync_cnt_r <= 4'h0;
      enable_r <= 1'b0;
      enable_pend_r <= 1'b0;
    end
    else if (!init_done_r)
      enable_r <= user_row.enable;
    else
    begin
      case (sync_r)
        SYNC_IDLE:
        begin
          if (ctrl_wr)
          begin
            enable_pend_r <= wdata[`BOD_ENABLE_BIT];
            sync_cnt_r <= 4'(SYNC_CYCLES - 1);
            sync_r <= SYNC_BUSY;
          end
        end
        SYNC_BUSY:
        begin
          // Enable-bit writes arriving while busy are ignored
          if (sync_cnt_r == 4'h0)
          begin
            enable_r <= enable_pend_r;
            sync_r <= SYNC_IDLE;
          end
          else
            sync_cnt_r <= sync_cnt_r - 4'h1;
        end
        default:
          sync_r <= SYNC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Operating mode selection
  // ----------------------------------------
  always_comb
  begin
    run_nxt = 1'b0;
    sampling_nxt = 1'b0;
    case (sleep_mode)
      MODE_ACTIVE:
      begin
        run_nxt = 1'b1;
        sampling_nxt = act_samp_r;
      end
      MODE_STANDBY:
      begin
        run_nxt = runsb_r;
        sampling_nxt = sbcfg_r;
      end
      MODE_BACKUP:
      begin
        run_nxt = runbk_r;
        sampling_nxt = 1'b1;
      end
      default:
      begin
        run_nxt = 1'b0;
        sampling_nxt = 1'b0;
      end
    endcase
    run_nxt = run_nxt && enable_r;
  end

  // ----------------------------------------
  // Sampling prescaler
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_cnt_r <= 16'h0000;
      sample_r <= 1'b0;
    end
    else
    begin
      sample_r <= 1'b0;
      if (!(run_nxt && sampling_nxt))
        pre_cnt_r <= 16'h0000;
      else if (osc_1khz_tick)
      begin
        if (pre_cnt_r >= pre_term(psel_r))
        begin
          pre_cnt_r <= 16'h0000;
          sample_r <= 1'b1;
        end
        else
          pre_cnt_r <= pre_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Comparator drive
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      comp_ctrl <= '0;
    else
    begin
      comp_ctrl.enable <= run_nxt && !sampling_nxt;
      comp_ctrl.sample <= run_nxt && sampling_nxt && sample_r;
      comp_ctrl.monitor_battery <= mon_batt_r;
      comp_ctrl.hysteresis <= hysteresis_r;
      if (mon_batt_r || sleep_mode == MODE_BACKUP)
        comp_ctrl.level <= batt_lvl_r;
      else
        comp_ctrl.level <= main_lvl_r;
    end
  end

  // ----------------------------------------
  // Ready and detection state
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ready_r <= 1'b0;
      det_r <= 1'b0;
      det_prev_r <= 1'b0;
    end
    else
    begin
      ready_r <= enable_r;
      det_prev_r <= det_r;
      if (!run_nxt)
        det_r <= 1'b0;
      else if (!sampling_nxt || comp_ctrl.sample)
        det_r <= comp_below;
    end
  end

  // ----------------------------------------
  // Crossing response
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bod_reset_req <= 1'b0;
      bod_int_req <= 1'b0;
      bod_backup_req <= 1'b0;
    end
    else
    begin
      bod_reset_req <= det_r && !det_prev_r && action_r == `BOD_ACT_RESET;
      bod_int_req <= det_r && !det_prev_r && action_r == `BOD_ACT_INT;
      bod_backup_req <= det_r && !det_prev_r && action_r == `BOD_ACT_BKUP && !mon_batt_r;
    end
  end

  // ----------------------------------------
  // Status and event flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_r <= 12'h000;
      status_prev_r <= 12'h000;
    end
    else
    begin
      status_prev_r <= status_r;
      status_r <= 12'h000;
      status_r[`BOD_ST_BATT] <= supply_in.battery_powered;
      status_r[`BOD_ST_CORE] <= supply_in.core_voltage_ok;
      status_r[`BOD_ST_APWS] <= supply_in.auto_switch_ready;
      status_r[`BOD_ST_VREG] <= supply_in.regulator_ready;
      status_r[`BOD_ST_SYNC] <= sync_r == SYNC_IDLE && !ctrl_wr;
      status_r[`BOD_ST_DET] <= det_r;
      status_r[`BOD_ST_RDY] <= ready_r;
    end
  end

  // Set on a rising status bit wins over a write-one clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flags_r <= 12'h000;
    else
    begin
      if (wr && addr == `BOD_OFF_FLAGS)
        flags_r <= (flags_r & ~wdata[11:0]) | (status_r & ~status_prev_r
                    & 12'(`BOD_FLAG_MASK));
      else
        flags_r <= flags_r | (status_r & ~status_prev_r & 12'(`BOD_FLAG_MASK));
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`BOD_BATT_LVL_HI:`BOD_BATT_LVL_LO] = batt_lvl_r;
    ctrl_word[`BOD_MAIN_LVL_HI:`BOD_MAIN_LVL_LO] = main_lvl_r;
    ctrl_word[`BOD_PSEL_HI:`BOD_PSEL_LO] = psel_r;
    ctrl_word[`BOD_MON_SEL_BIT] = mon_batt_r;
    ctrl_word[`BOD_ACT_SAMP_BIT] = act_samp_r;
    ctrl_word[`BOD_RUNBK_BIT] = runbk_r;
    ctrl_word[`BOD_RUNSB_BIT] = runsb_r;
    ctrl_word[`BOD_SBCFG_BIT] = sbcfg_r;
    ctrl_word[`BOD_ACTION_HI:`BOD_ACTION_LO] = action_r;
    ctrl_word[`BOD_HYSTERESIS_BIT] = hysteresis_r;
    ctrl_word[`BOD_ENABLE_BIT] = enable_r;
    status_word = {20'h00000, status_r};
    if (addr == `BOD_OFF_CONTROL)
      rdata_nxt = ctrl_word;
    else if (addr == `BOD_OFF_STATUS)
      rdata_nxt = status_word;
    else if (addr == `BOD_OFF_FLAGS)
      rdata_nxt = {20'h00000, flags_r};
    else
      rdata_nxt = 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 32'h0000_0000;
    else if (rd)
      rdata <= rdata_nxt;
    else
      rdata <= 32'h0000_0000;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_ctrl_write;
    ctrl_wr && sync_r == SYNC_IDLE;
  endsequence

  sequence s_sync_done;
    sync_r == SYNC_IDLE && enable_r == $past(enable_pend_r);
  endsequence

  chk_status_batt: assert property (
    init_done_r |-> status_r[`BOD_ST_BATT] == $past(supply_in.battery_powered))
    else $error("battery status bit does not follow supply");

  chk_status_core: assert property (
    init_done_r |=> status_r[`BOD_ST_CORE] == $past(supply_in.core_voltage_ok))
    else $error("core ready bit does not follow supply");

  chk_status_apws: assert property (
    init_done_r |-> status_r[`BOD_ST_APWS] == $past(supply_in.auto_switch_ready))
    else $error("power switch ready bit wrong");

  chk_status_vreg: assert property (
    init_done_r |-> status_r[`BOD_ST_VREG] == $past(supply_in.regulator_ready))
    else $error("regulator ready bit wrong");

  chk_sync_busy_low: assert property (
    s_ctrl_write |=> !status_r[`BOD_ST_SYNC] [*3])
    else $error("sync ready high during synchronisation");

  chk_sync_completes: assert property (
    s_ctrl_write |-> ##[1:16] s_sync_done)
    else $error("enable write never synchronised");

  chk_det_idle: assert property (
    !run_nxt |=> !det_r)
    else $error("detection set while detector off");

  chk_sample_period: assert property (
    comp_ctrl.sample |=> !comp_ctrl.sample)
    else $error("sample strobe longer than one cycle");

  chk_level_pick: assert property (
    mon_batt_r |=> comp_ctrl.level == $past(batt_lvl_r))
    else $error("battery threshold not applied");

  chk_backup_act: assert property (
    bod_backup_req |-> $past(!mon_batt_r) && $past(action_r) == `BOD_ACT_BKUP)
    else $error("backup request with wrong action");

  chk_protect: assert property (
    (enable_r && init_done_r && $past(init_done_r)) |=> $stable(psel_r))
    else $error("protected field changed while enabled");

endmodule // io_brownout_ctrl_status

`default_nettype wire

// file: testbench/bod_analog_model.sv
// Comparator and low-power oscillator standing beside the brown-out block.
// Assumes the bench drives supply_low to model a sagging supply.
`timescale 1ns/1ps
`default_nettype none

module bod_analog_model
#(
  parameter int TICK_CYCLES = 10
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic supply_low,
  input wire io_bod_pkg::comp_ctrl_t comp_ctrl,
  output logic comp_below,
  output logic osc_1khz_tick
);
  import io_bod_pkg::*;
  int cnt;

  // ----------------------------------------
  // Oscillator tick, sped up to keep sampling periods short
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 0;
      osc_1khz_tick <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == TICK_CYCLES - 1) ? 0 : cnt + 1;
      osc_1khz_tick <= (cnt == TICK_CYCLES - 1);
    end
  end

  // ----------------------------------------
  // Comparator answers only while powered or strobed
  // ----------------------------------------
  assign comp_below = supply_low & (comp_ctrl.enable | comp_ctrl.sample);
endmodule // bod_analog_model
`default_nettype wire

// file: testbench/io_brownout_ctrl_status_tb_top.sv
// Self-checking bench for the brown-out control and status block.
// Assumes package, constants header and analog model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "io_bod_consts.svh"
`define CHK(nm, e, g) \
  begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end

module io_brownout_ctrl_status_tb_top;
  import io_bod_pkg::*;
  logic clk, rstn, wr, rd, write_lock, supply_low;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  user_row_t user_row;
  supply_in_t supply_in;
  sleep_mode_t sleep_mode;
  logic osc_1khz_tick, comp_below, bod_reset_req, bod_int_req, bod_backup_req;
  comp_ctrl_t comp_ctrl;
  int fails, num_checks, cycles, n_rst, n_int, n_bk, n_samp, last_s, last_gap;
  sleep_mode_t md[8];
  logic [31:0] cf[8];
  logic en[8];
  int gp[8];
  logic [5:0] lv[8];

  io_brownout_ctrl_status #(.SYNC_CYCLES(3)) io_brownout_ctrl_status_inst (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .write_lock(write_lock), .user_row(user_row),
    .supply_in(supply_in), .sleep_mode(sleep_mode), .osc_1khz_tick(osc_1khz_tick),
    .comp_below(comp_below), .comp_ctrl(comp_ctrl), .bod_reset_req(bod_reset_req),
    .bod_int_req(bod_int_req), .bod_backup_req(bod_backup_req));

  bod_analog_model #(.TICK_CYCLES(10)) bod_analog_model_inst (
    .clk(clk), .rstn(rstn), .supply_low(supply_low), .comp_ctrl(comp_ctrl),
    .comp_below(comp_below), .osc_1khz_tick(osc_1khz_tick));

  // ----------------------------------------
  // Clock, event counters and timeout
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (bod_reset_req === 1'b1) n_rst++;
    if (bod_int_req === 1'b1) n_int++;
    if (bod_backup_req === 1'b1) n_bk++;
    if (comp_ctrl.sample === 1'b1)
    begin
      last_gap = cycles - last_s;
      last_s = cycles;
      n_samp++;
    end
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      final_report();
    end
  end

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  function automatic logic [31:0] mk(input logic [3:0] ps, input logic vm, ac, bk, sb, sc,
                                     input logic [1:0] act);
    mk = {2'h0, 6'h2a, 2'h0, 6'h15, ps, 1'b0, vm, 1'b0, ac, bk, sb, sc, act, 3'h0};
  endfunction

  // Disable, load fields, then enable and watch the sync handshake
  task automatic setcfg(input logic [31:0] v);
    wr_reg(`BOD_OFF_CONTROL, 32'h0);
    wait_cyc(10);
    wr_reg(`BOD_OFF_CONTROL, v);
    wait_cyc(10);
    wr_reg(`BOD_OFF_CONTROL, v | 32'h2);
    rd_reg(`BOD_OFF_STATUS, rv);
    `CHK("sync busy", 1'b0, rv[`BOD_ST_SYNC])
    wait_cyc(10);
    rd_reg(`BOD_OFF_STATUS, rv);
    `CHK("sync done", 1'b1, rv[`BOD_ST_SYNC])
    `CHK("ready", 1'b1, rv[`BOD_ST_RDY])
    rd_reg(`BOD_OFF_CONTROL, rv);
    `CHK("control", v | 32'h2, rv)
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    write_lock = 1'b0;
    supply_low = 1'b0;
    supply_in = '0;
    sleep_mode = MODE_ACTIVE;
    user_row = '{action: 2'h2, enable: 1'b0, hysteresis: 1'b1, level: 6'h15};
    md = '{MODE_ACTIVE, MODE_ACTIVE, MODE_ACTIVE, MODE_STANDBY, MODE_STANDBY,
           MODE_STANDBY, MODE_BACKUP, MODE_BACKUP};
    cf = '{mk(0, 1, 0, 0, 0, 0, 0), mk(0, 0, 1, 0, 0, 0, 0), mk(2, 0, 1, 0, 0, 0, 0),
           mk(0, 0, 0, 0, 0, 0, 0), mk(0, 0, 0, 0, 1, 0, 0), mk(1, 0, 0, 0, 1, 1, 0),
           mk(0, 0, 0, 0, 0, 0, 0), mk(0, 0, 0, 1, 0, 0, 0)};
    en = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    gp = '{0, 20, 80, 0, 0, 40, 0, 20};
    lv = '{6'h2a, 6'h15, 6'h15, 6'h15, 6'h15, 6'h15, 6'h2a, 6'h2a};
    wait_cyc(12);
    rstn <= 1'b1;
    wait_cyc(4);
    rd_reg(`BOD_OFF_CONTROL, rv);
    `CHK("ctrl reset", 32'h0015_0014, rv)
    rd_reg(`BOD_OFF_STATUS, rv);
    `CHK("rdy reset", 1'b0, rv[`BOD_ST_RDY])
    rd_reg(8'h40, rv);
    `CHK("unmapped", 32'h0, rv)
    for (int i = 0; i < 4; i++)
    begin
      supply_in <= supply_in_t'(4'h1 << i);
      wait_cyc(3);
      rd_reg(`BOD_OFF_STATUS, rv);
      `CHK("supply bits", 4'h1 << i, rv[11:8])
    end
    for (int i = 0; i < 8; i++)
    begin
      sleep_mode <= md[i];
      setcfg(cf[i]);
      n_samp = 0;
      wait_cyc(400);
      `CHK("run", en[i], comp_ctrl.enable)
      `CHK("gap", gp[i], (n_samp == 0) ? 0 : last_gap)
      `CHK("level", lv[i], comp_ctrl.level)
      `CHK("vbat", cf[i][10], comp_ctrl.monitor_battery)
    end
    sleep_mode <= MODE_ACTIVE;
    for (int i = 0; i < 5; i++)
    begin
      setcfg(mk(0, i == 4, 0, 0, 0, 0, (i == 4) ? 2'h3 : 2'(i)));
      n_rst = 0;
      n_int = 0;
      n_bk = 0;
      supply_low <= 1'b1;
      wait_cyc(10);
      rd_reg(`BOD_OFF_STATUS, rv);
      `CHK("detect", 1'b1, rv[`BOD_ST_DET])
      supply_low <= 1'b0;
      wait_cyc(10);
      `CHK("rst req", (i == 1) ? 1 : 0, n_rst)
      `CHK("int req", (i == 2) ? 1 : 0, n_int)
      `CHK("bkup req", (i == 3) ? 1 : 0, n_bk)
    end
    rd_reg(`BOD_OFF_FLAGS, rv);
    `CHK("det flag", 1'b1, rv[`BOD_ST_DET])
    wr_reg(`BOD_OFF_FLAGS, 32'h0);
    rd_reg(`BOD_OFF_FLAGS, rv);
    `CHK("flag kept", 1'b1, rv[`BOD_ST_DET])
    wr_reg(`BOD_OFF_FLAGS, 32'h2);
    rd_reg(`BOD_OFF_FLAGS, rv);
    `CHK("flag clear", 1'b0, rv[`BOD_ST_DET])
    wr_reg(`BOD_OFF_CONTROL, mk(5, 0, 1, 1, 1, 1, 2'h1) | 32'h2);
    wait_cyc(10);
    rd_reg(`BOD_OFF_CONTROL, rv);
    `CHK("protected", mk(0, 1, 0, 0, 0, 0, 2'h3) | 32'h2, rv)
    write_lock <= 1'b1;
    wr_reg(`BOD_OFF_CONTROL, 32'h0);
    wait_cyc(10);
    rd_reg(`BOD_OFF_CONTROL, rv);
    `CHK("locked", mk(0, 1, 0, 0, 0, 0, 2'h3) | 32'h2, rv)
    write_lock <= 1'b0;
    // Second reset in mid-run with the detector enabled from the user row
    user_row <= '{action: 2'h1, enable: 1'b1, hysteresis: 1'b1, level: 6'h0a};
    rstn <= 1'b0;
    wait_cyc(3);
    rstn <= 1'b1;
    wait_cyc(4);
    rd_reg(`BOD_OFF_CONTROL, rv);
    `CHK("ctrl user row", 32'h000a_000e, rv)
    rd_reg(`BOD_OFF_STATUS, rv);
    `CHK("rdy user row", 1'b1, rv[`BOD_ST_RDY])
    `CHK("level user row", 6'h0a, comp_ctrl.level)
    `CHK("run user row", 1'b1, comp_ctrl.enable)
    final_report();
  end
endmodule // io_brownout_ctrl_status_tb_top
`default_nettype wire
